// ---- sac_pkg.sv ----
// constants and types shared by the stack alu carry datapath
// Overview of operation
// - result of top and operand loads top
// - single-step math takes second stack register
// - single-step operations finish in one cycle
// - boolean codes for long and short fields
// - arithmetic codes for long and short fields
// - carry flag is config bit zero, writable
// - add/subtract load carry, logic leaves it
// - only three codes use stored carry
// - addition carry-out one means overflow
// - subtract adds complement, carry zero borrows
// - plain subtract uses carry-in one
// - sixteen-bit datapath through shift stage
package sac_pkg;
    localparam int DATA_W = 16;
    localparam int CARRY_BIT = 0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [DATA_W-1:0] TOP_RST = 16'h0000;
    localparam logic [DATA_W-1:0] NEXT_RST = 16'h0000;
    localparam logic [3:0] FN_AND = 4'h2;
    localparam logic [3:0] FN_NOR = 4'h3;
    localparam logic [3:0] FN_TSUB = 4'h4;
    localparam logic [3:0] FN_TSUBB = 4'h5;
    localparam logic [3:0] FN_OR = 4'h6;
    localparam logic [3:0] FN_NAND = 4'h7;
    localparam logic [3:0] FN_ADD = 4'h8;
    localparam logic [3:0] FN_ADDC = 4'h9;
    localparam logic [3:0] FN_XOR = 4'hA;
    localparam logic [3:0] FN_XNOR = 4'hB;
    localparam logic [3:0] FN_YSUB = 4'hC;
    localparam logic [3:0] FN_YSUBB = 4'hD;
    localparam logic [2:0] SF_AND = 3'h1;
    localparam logic [2:0] SF_TSUB = 3'h2;
    localparam logic [2:0] SF_OR = 3'h3;
    localparam logic [2:0] SF_ADD = 3'h4;
    localparam logic [2:0] SF_XOR = 3'h5;
    localparam logic [2:0] SF_YSUB = 3'h6;
    localparam logic [1:0] YSEL_NEXT = 2'h0;
    localparam logic [1:0] YSEL_EXT = 2'h1;
    typedef enum logic [1:0] {SAC_OP_LOAD, SAC_OP_ALU, SAC_OP_CARRY} sac_op_t;
endpackage

// ---- sac_fn_decode.sv ----
// maps the long or short function field to one long-field code
`timescale 1ns/1ps
module sac_fn_decode (
    input wire logic [3:0] fn_long,
    input wire logic [2:0] fn_short,
    input wire logic use_short,
    output logic [3:0] fn_code,
    output logic fn_valid
);
    // short field expands to the matching long code
    always_comb
    begin
        fn_code = fn_long;
        fn_valid = 1'b1;
        if (use_short)
        begin
            unique case (fn_short)
                sac_pkg::SF_AND: fn_code = sac_pkg::FN_AND;
                sac_pkg::SF_OR: fn_code = sac_pkg::FN_OR;
                sac_pkg::SF_XOR: fn_code = sac_pkg::FN_XOR;
                sac_pkg::SF_TSUB: fn_code = sac_pkg::FN_TSUB;
                sac_pkg::SF_ADD: fn_code = sac_pkg::FN_ADD;
                sac_pkg::SF_YSUB: fn_code = sac_pkg::FN_YSUB;
                default:
                begin
                    fn_code = fn_long;
                    fn_valid = 1'b0;
                end
            endcase
        end
        else
        begin
            fn_valid = (fn_long >= sac_pkg::FN_AND) && (fn_long <= sac_pkg::FN_YSUBB);
        end
    end
endmodule

// ---- sac_alu_core.sv ----
// combinational 16-bit alu with carry in and carry out
`timescale 1ns/1ps
module sac_alu_core (
    input wire logic [3:0] fn_code,
    input wire logic [15:0] top_in,
    input wire logic [15:0] y_in,
    input wire logic carry_in,
    output logic [15:0] result,
    output logic carry_out,
    output logic carry_write
);
    logic [16:0] sum;
    logic [15:0] opa;
    logic [15:0] opb;
    logic cin;
    // arithmetic: a plus complement of b plus carry-in for subtract
    always_comb
    begin
        opa = top_in;
        opb = y_in;
        cin = 1'b0;
        carry_write = 1'b0;
        result = 16'h0000;
        unique case (fn_code)
            sac_pkg::FN_AND: result = top_in & y_in;
            sac_pkg::FN_NOR: result = ~(top_in | y_in);
            sac_pkg::FN_OR: result = top_in | y_in;
            sac_pkg::FN_NAND: result = ~(top_in & y_in);
            sac_pkg::FN_XOR: result = top_in ^ y_in;
            sac_pkg::FN_XNOR: result = ~(top_in ^ y_in);
            sac_pkg::FN_ADD, sac_pkg::FN_ADDC:
            begin
                cin = (fn_code == sac_pkg::FN_ADDC) ? carry_in : 1'b0;
                carry_write = 1'b1;
            end
            sac_pkg::FN_TSUB, sac_pkg::FN_TSUBB:
            begin
                opb = ~y_in;
                cin = (fn_code == sac_pkg::FN_TSUBB) ? carry_in : 1'b1;
                carry_write = 1'b1;
            end
            sac_pkg::FN_YSUB, sac_pkg::FN_YSUBB:
            begin
                opa = y_in;
                opb = ~top_in;
                cin = (fn_code == sac_pkg::FN_YSUBB) ? carry_in : 1'b1;
                carry_write = 1'b1;
            end
            default: result = top_in;
        endcase
        sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
        if (carry_write)
        begin
            result = sum[15:0];
        end
        carry_out = sum[16];
    end
endmodule

// ---- sac_datapath.sv ----
// top of the stack alu: top/next registers, carry flag, shift stage
`timescale 1ns/1ps
module sac_datapath (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] op_sel,
    input wire logic [3:0] fn_long,
    input wire logic [2:0] fn_short,
    input wire logic use_short,
    input wire logic [1:0] y_sel,
    input wire logic [15:0] y_ext,
    input wire logic [3:0] shift_sel,
    input wire logic [15:0] load_data,
    input wire logic load_next,
    input wire logic [15:0] next_load_data,
    input wire logic carry_wr,
    input wire logic carry_wr_data,
    output logic [15:0] top_q,
    output logic [15:0] next_q,
    output logic [15:0] config_reg,
    output logic carry_flag,
    output logic fn_illegal
);
    logic [15:0] top_r;
    logic [15:0] top_nxt;
    logic [15:0] next_r;
    logic [15:0] next_nxt;
    logic carry_r;
    logic carry_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic [3:0] fn_code;
    logic fn_valid;
    logic [15:0] y_mux;
    logic [15:0] z;
    logic alu_cout;
    logic alu_cwr;
    logic cy_after;
    sac_pkg::sac_op_t op;

    assign op = sac_pkg::sac_op_t'(op_sel);

    // second operand: next register for single-step math
    always_comb
    begin
        y_mux = (y_sel == sac_pkg::YSEL_EXT) ? y_ext : next_r;
    end

    sac_fn_decode u_dec (
        .fn_long(fn_long),
        .fn_short(fn_short),
        .use_short(use_short),
        .fn_code(fn_code),
        .fn_valid(fn_valid)
    );

    sac_alu_core u_alu (
        .fn_code(fn_code),
        .top_in(top_r),
        .y_in(y_mux),
        .carry_in(carry_r),
        .result(z),
        .carry_out(alu_cout),
        .carry_write(alu_cwr)
    );

    // next state: alu plus shift stage, carry and top on one edge
    always_comb
    begin
        top_nxt = top_r;
        next_nxt = load_next ? next_load_data : next_r;
        carry_nxt = carry_r;
        illegal_nxt = illegal_r;
        cy_after = carry_r;
        unique case (op)
            sac_pkg::SAC_OP_LOAD:
            begin
                top_nxt = load_data;
            end
            sac_pkg::SAC_OP_ALU:
            begin
                illegal_nxt = ~fn_valid;
                cy_after = (fn_valid && alu_cwr) ? alu_cout : carry_r;
                top_nxt = fn_valid ? z : top_r;
                carry_nxt = cy_after;
                if (fn_valid)
                begin
                    unique case (shift_sel)
                        4'h0: top_nxt = z;
                        4'h1: top_nxt = {16{z[15]}};
                        4'h2:
                        begin
                            top_nxt = {z[14:0], 1'b0};
                            carry_nxt = z[15];
                        end
                        4'h3:
                        begin
                            top_nxt = {z[14:0], cy_after};
                            carry_nxt = z[15];
                        end
                        4'h4:
                        begin
                            top_nxt = {cy_after, z[15:1]};
                            carry_nxt = 1'b0;
                        end
                        4'h5:
                        begin
                            top_nxt = {cy_after, z[15:1]};
                            carry_nxt = z[0];
                        end
                        4'h6:
                        begin
                            top_nxt = {1'b0, z[15:1]};
                            carry_nxt = 1'b0;
                        end
                        4'h7:
                        begin
                            top_nxt = {z[15], z[15:1]};
                            carry_nxt = z[15];
                        end
                        4'h8: next_nxt = {next_r[14:0], 1'b0};
                        4'h9: next_nxt = {next_r[14:0], cy_after};
                        4'hA:
                        begin
                            top_nxt = {z[14:0], next_r[15]};
                            next_nxt = {next_r[14:0], 1'b0};
                            carry_nxt = z[15];
                        end
                        4'hB:
                        begin
                            top_nxt = {z[14:0], next_r[15]};
                            next_nxt = {next_r[14:0], cy_after};
                            carry_nxt = z[15];
                        end
                        4'hC:
                        begin
                            top_nxt = {cy_after, z[15:1]};
                            next_nxt = {z[0], next_r[15:1]};
                            carry_nxt = 1'b0;
                        end
                        4'hD:
                        begin
                            top_nxt = {cy_after, z[15:1]};
                            next_nxt = {z[0], next_r[15:1]};
                            carry_nxt = next_r[0];
                        end
                        4'hE:
                        begin
                            top_nxt = {1'b0, z[15:1]};
                            next_nxt = {z[0], next_r[15:1]};
                            carry_nxt = 1'b0;
                        end
                        default: top_nxt = z;
                    endcase
                end
            end
            sac_pkg::SAC_OP_CARRY:
            begin
                illegal_nxt = 1'b0;
            end
            default:
            begin
                illegal_nxt = 1'b1;
            end
        endcase
        if (carry_wr)
        begin
            carry_nxt = carry_wr_data;
        end
    end

    // state registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            top_r <= sac_pkg::TOP_RST;
            next_r <= sac_pkg::NEXT_RST;
            carry_r <= sac_pkg::CARRY_RST;
            illegal_r <= 1'b0;
        end
        else
        begin
            top_r <= top_nxt;
            next_r <= next_nxt;
            carry_r <= carry_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    // outputs straight from flip-flops
    assign top_q = top_r;
    assign next_q = next_r;
    assign carry_flag = carry_r;
    assign fn_illegal = illegal_r;
    assign config_reg = {15'h0000, carry_r};
endmodule

// ---- sac_datapath_properties.sv ----
// checker for the stack alu datapath ports
`timescale 1ns/1ps
module sac_datapath_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] op_sel,
    input wire logic [3:0] fn_long,
    input wire logic [2:0] fn_short,
    input wire logic use_short,
    input wire logic [1:0] y_sel,
    input wire logic [15:0] y_ext,
    input wire logic [3:0] shift_sel,
    input wire logic [15:0] load_data,
    input wire logic load_next,
    input wire logic carry_wr,
    input wire logic carry_wr_data,
    input wire logic [15:0] top_q,
    input wire logic [15:0] next_q,
    input wire logic [15:0] config_reg,
    input wire logic carry_flag,
    input wire logic fn_illegal
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic go;
    logic gs;
    // plain alu cycle: no shift, no next load, no carry write
    assign gs = op_sel == 2'h1 && shift_sel == 4'hF && !carry_wr && !load_next;
    assign go = gs && !use_short;
    property p_add;
        go && y_sel == 2'h0 && fn_long == 4'h8 |=> top_q == $past(top_q) + $past(next_q)
            && carry_flag == (top_q < $past(top_q));
    endproperty
    a_add: assert property (p_add) else $error("add or carry wrong");
    property p_tsub;
        go && y_sel == 2'h0 && fn_long == 4'h4 |=> top_q == $past(top_q) - $past(next_q)
            && carry_flag == ($past(top_q) >= $past(next_q));
    endproperty
    a_tsub: assert property (p_tsub) else $error("subtract wrong");
    property p_ysubb;
        go && y_sel == 2'h0 && fn_long == 4'hD
            |=> top_q == $past(next_q) - $past(top_q) - {15'h0, ~$past(carry_flag)};
    endproperty
    a_ysubb: assert property (p_ysubb) else $error("borrow subtract wrong");
    property p_logic;
        go && fn_long inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB} |=> $stable(carry_flag);
    endproperty
    a_logic: assert property (p_logic) else $error("logic op moved carry");
    property p_ext;
        go && y_sel == 2'h1 && fn_long == 4'h2 |=> top_q == ($past(top_q) & $past(y_ext));
    endproperty
    a_ext: assert property (p_ext) else $error("external and wrong");
    property p_short;
        gs && use_short && y_sel == 2'h0 && fn_short == 3'h6
            |=> top_q == $past(next_q) - $past(top_q);
    endproperty
    a_short: assert property (p_short) else $error("short reverse subtract wrong");
    property p_cwr;
        carry_wr |=> carry_flag == $past(carry_wr_data);
    endproperty
    a_cwr: assert property (p_cwr) else $error("carry write lost");
    property p_cfg;
        config_reg == {15'h0, carry_flag};
    endproperty
    a_cfg: assert property (p_cfg) else $error("config bit zero differs");
    property p_load;
        op_sel == 2'h0 |=> top_q == $past(load_data);
    endproperty
    a_load: assert property (p_load) else $error("top load wrong");
    // an illegal long code leaves top and carry alone and raises the flag
    property p_illegal;
        op_sel == 2'h1 && !use_short && fn_long inside {4'h0, 4'h1, 4'hE, 4'hF} && !carry_wr
            && !load_next |=> fn_illegal && $stable(top_q) && $stable(carry_flag);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal code not refused");
    cover property (go && fn_long == 4'h5 ##1 !carry_flag);
    cover property (fn_illegal);
    cover property (carry_wr ##1 carry_flag);
endmodule
bind sac_datapath sac_datapath_checker u_chk (.*);

// ---- sac_stack_model.sv ----
// stack control model that loads the next register
`timescale 1ns/1ps
module sac_stack_model (
    input wire logic sys_clk,
    input wire logic push,
    input wire logic [15:0] push_data,
    output logic load_next,
    output logic [15:0] next_load_data
);
    logic [15:0] junk_r = 16'hA5C3;
    // idle bus toggles so a stale value is never trusted
    always_ff @(posedge sys_clk)
    begin
        junk_r <= ~junk_r;
    end
    // push passes straight to the next register load
    assign load_next = push;
    assign next_load_data = push ? push_data : junk_r;
endmodule

// ---- testbench.sv ----
// self-checking bench for the stack alu datapath
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] op_sel = 2'h2;
    logic [3:0] fn_long = 4'h2;
    logic [2:0] fn_short = 3'h1;
    logic use_short = 1'b0;
    logic [1:0] y_sel = 2'h0;
    logic [15:0] y_ext = 16'h0F0F;
    logic [3:0] shift_sel = 4'hF;
    logic [15:0] load_data = 16'h0000;
    logic push = 1'b0;
    logic [15:0] push_data = 16'h0000;
    logic carry_wr = 1'b0;
    logic carry_wr_data = 1'b0;
    logic load_next;
    logic [15:0] next_load_data, top_q, next_q, config_reg;
    logic carry_flag, fn_illegal;
    int errors = 0;
    int n_checks = 0;
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    sac_stack_model u_stk (.sys_clk(sys_clk), .push(push), .push_data(push_data),
        .load_next(load_next), .next_load_data(next_load_data));
    sac_datapath u_dut (.sys_clk(sys_clk), .rst(rst), .op_sel(op_sel), .fn_long(fn_long),
        .fn_short(fn_short), .use_short(use_short), .y_sel(y_sel), .y_ext(y_ext),
        .shift_sel(shift_sel), .load_data(load_data), .load_next(load_next),
        .next_load_data(next_load_data), .carry_wr(carry_wr), .carry_wr_data(carry_wr_data),
        .top_q(top_q), .next_q(next_q), .config_reg(config_reg), .carry_flag(carry_flag),
        .fn_illegal(fn_illegal));
    // reference: carry in bit 16, logic keeps carry
    function automatic logic [16:0] rf(logic [3:0] f, logic [15:0] t, logic [15:0] y, logic c);
        case (f)
            4'h2: return {c, t & y};
            4'h3: return {c, ~(t | y)};
            4'h6: return {c, t | y};
            4'h7: return {c, ~(t & y)};
            4'hA: return {c, t ^ y};
            4'hB: return {c, ~(t ^ y)};
            4'h8: return t + y;
            4'h9: return t + y + c;
            4'h4: return t + {1'b0, ~y} + 17'h1;
            4'h5: return t + {1'b0, ~y} + c;
            4'hC: return y + {1'b0, ~t} + 17'h1;
            default: return y + {1'b0, ~t} + c;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic setv(input logic [15:0] t, input logic [15:0] n, input logic c);
        op_sel = 2'h0;
        load_data = t;
        push = 1'b1;
        push_data = n;
        carry_wr = 1'b1;
        carry_wr_data = c;
        @(negedge sys_clk);
    endtask
    task automatic run(input logic [3:0] f, input logic [2:0] s, input logic u,
        input logic [1:0] ys);
        op_sel = 2'h1;
        fn_long = f;
        fn_short = s;
        use_short = u;
        y_sel = ys;
        push = 1'b0;
        carry_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    // every legal long and short code against four operand sets
    task automatic t_alu();
        logic [3:0] fl [18] = '{4'h8, 4'h9, 4'h4, 4'h5, 4'hC, 4'hD, 4'h2, 4'h3, 4'h6, 4'h7,
            4'hA, 4'hB, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
        logic [15:0] tv [4] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h8000};
        logic [15:0] nv [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h8000};
        logic cv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic [16:0] e;
        foreach (fl[i])
            for (int j = 0; j < 4; j++)
            begin
                setv(tv[j], nv[j], cv[j]);
                e = rf(fl[i], tv[j], nv[j], cv[j]);
                run(fl[i], 3'(i - 11), i > 11, 2'h0);
                chk(top_q, e[15:0]);
                chk({15'h0, carry_flag}, {15'h0, e[16]});
            end
        $display("alu codes done");
    endtask
    // each shift code 0 to E after an add of C001 and 8000: alu result 4001, carry 1
    task automatic t_shift();
        logic [15:0] et [15] = '{16'h4001, 16'h0000, 16'h8002, 16'h8003, 16'hA000, 16'hA000,
            16'h2000, 16'h2000, 16'h4001, 16'h4001, 16'h8003, 16'h8003, 16'hA000, 16'hA000,
            16'h2000};
        logic [15:0] en [15] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
            16'h8000, 16'h8000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'hC000, 16'hC000,
            16'hC000};
        logic [14:0] ec = 15'h0323; // expected carry per shift code, bit k for code k
        for (int k = 0; k < 15; k++)
        begin
            setv(16'hC001, 16'h8000, 1'b0);
            shift_sel = 4'(k);
            run(4'h8, 3'h1, 1'b0, 2'h0);
            shift_sel = 4'hF;
            chk(top_q, et[k]);
            chk(next_q, en[k]);
            chk({15'h0, carry_flag}, {15'h0, ec[k]});
        end
        $display("shift stage done");
    endtask
    // operand from outside, illegal codes, carry write priority
    task automatic t_misc();
        setv(16'h3C3C, 16'h1234, 1'b1);
        chk(next_q, 16'h1234);
        run(4'h2, 3'h1, 1'b0, 2'h1);
        chk(top_q, 16'h0C0C);
        run(4'h0, 3'h1, 1'b0, 2'h0);
        chk({15'h0, fn_illegal}, 16'h0001);
        chk(top_q, 16'h0C0C);
        chk(config_reg, 16'h0001);
        setv(16'hFFFF, 16'h0001, 1'b1);
        // add whose carry-out of 1 loses to a carry write in the same cycle
        op_sel = 2'h1;
        fn_long = 4'h8;
        push = 1'b0;
        carry_wr = 1'b1;
        carry_wr_data = 1'b0;
        @(negedge sys_clk);
        carry_wr = 1'b0;
        chk(top_q, 16'h0000);
        chk(config_reg, 16'h0000);
        chk({15'h0, fn_illegal}, 16'h0000);
        // short code 111 is refused, then carry-only and illegal selects
        run(4'h8, 3'h7, 1'b1, 2'h0);
        chk({15'h0, fn_illegal}, 16'h0001);
        chk(top_q, 16'h0000);
        op_sel = 2'h2;
        @(negedge sys_clk);
        chk({15'h0, fn_illegal}, 16'h0000);
        op_sel = 2'h3;
        @(negedge sys_clk);
        chk({15'h0, fn_illegal}, 16'h0001);
        op_sel = 2'h2;
        $display("misc done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        errors++;
        $display("ERROR %0t run timed out", $time);
        results();
    end
    initial
    begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        chk(top_q, 16'h0000);
        chk(config_reg, 16'h0000);
        $display("reset done");
        t_alu();
        t_shift();
        t_misc();
        results();
    end
endmodule
